// [hw/sso_status_outputs.sv]
// servo status outputs: alarm latch, motion detect, ready, index, overtravel, excitation
// assumes pins are asynchronous, drive-internal status inputs are on clk
//
// Chosen here: the register addresses and the strobed register port.
`include "sso_map.svh"

module sso_status_outputs
  import sso_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic [`SSO_ADDR_W-1:0]        reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  input  wire logic                          fault_clear_in_n,
  input  wire logic                          fwd_limit_in_n,
  input  wire logic                          rev_limit_in_n,
  input  wire logic                          index_in,
  input  wire logic                          alarm_detect,
  input  wire logic                          panel_clear,
  input  wire logic [`SSO_SPEED_W-1:0]       motor_speed,
  input  wire logic                          prep_done,
  input  wire logic                          main_power_ok,
  input  wire logic                          motor_energised,
  output logic                               fault_flag_out,
  output logic      [`SSO_PAIRS-1:0]         pin_pair_out,
  output logic                               irq
);

  localparam int NPIN = 4;
  localparam int NDEB = 3;
  localparam logic [`SSO_DEB_W-1:0] DEB_CYC = `SSO_DEB_W'(`SSO_DEBOUNCE_CYC);
  localparam logic [`SSO_DEB_W-1:0] DEB_LAST = DEB_CYC - 8'h01;

  logic [NPIN-1:0]           sync1_q;
  logic [NPIN-1:0]           sync2_q;
  logic [NDEB-1:0]           deb_q;
  logic [`SSO_DEB_W-1:0]     deb_cnt_q [NDEB];
  logic                      alarm_q;
  logic                      motion_q;
  logic                      ready_q;
  logic                      index_q;
  logic                      travel_q;
  logic                      travel_d;
  logic                      excite_q;
  logic                      servo_on_q;
  logic [`SSO_SPEED_W-1:0]   thresh_q;
  logic [1:0]                limcfg_pend_q;
  logic [1:0]                limcfg_act_q;
  logic [11:0]               pinsel_q;
  logic [`SSO_IRQ_W-1:0]     irq_stat_q;
  logic [`SSO_IRQ_W-1:0]     irq_en_q;
  logic [`SSO_IRQ_W-1:0]     irq_event;
  logic [`SSO_IRQ_W-1:0]     irq_clr;
  logic                      clr_req;
  logic                      wr_ctrl;
  logic [31:0]               rdata_d;

  always_ff @(posedge clk) begin
    if (reset) begin
      // index idles low: resetting its stages high would fake a pulse
      sync1_q <= 4'h7;
      sync2_q <= 4'h7;
    end else if (clk_en) begin
      sync1_q <= {index_in, rev_limit_in_n, fwd_limit_in_n, fault_clear_in_n};
      sync2_q <= sync1_q;
    end
  end

  // debounce filters
  // index is not filtered: its width is speed dependent and must stay intact
  generate
    for (genvar i = 0; i < NDEB; i++) begin : g_deb
      always_ff @(posedge clk) begin
        if (reset) begin
          deb_q[i]     <= 1'b1;
          deb_cnt_q[i] <= '0;
        end else if (clk_en) begin
          if (sync2_q[i] == deb_q[i]) begin
            deb_cnt_q[i] <= '0;
          end else if (deb_cnt_q[i] == DEB_CYC - 8'h01) begin
            deb_q[i]     <= sync2_q[i];
            deb_cnt_q[i] <= '0;
          end else begin
            deb_cnt_q[i] <= deb_cnt_q[i] + 8'h01;
          end
        end
      end
    end
  endgenerate

  assign clr_req = ~deb_q[0] | panel_clear;

  // alarm latch, a new alarm wins over a clear
  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_q <= 1'b0;
    end else if (clk_en) begin
      if (alarm_detect) begin
        alarm_q <= 1'b1;
      end else if (clr_req) begin
        alarm_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_flag_out <= 1'b0;
    end else if (clk_en) begin
      fault_flag_out <= alarm_detect | (alarm_q & ~clr_req);
    end
  end

  // overtravel level, shared with the event detector
  assign travel_d = (~deb_q[1] & ~limcfg_act_q[0]) | (~deb_q[2] & ~limcfg_act_q[1]);

  // status detectors, one stage each
  always_ff @(posedge clk) begin
    if (reset) begin
      motion_q <= 1'b0;
      ready_q  <= 1'b0;
      index_q  <= 1'b0;
      travel_q <= 1'b0;
      excite_q <= 1'b0;
    end else if (clk_en) begin
      motion_q <= motor_speed > thresh_q;
      ready_q  <= servo_on_q & prep_done & ~alarm_q & main_power_ok;
      index_q  <= sync2_q[3];
      travel_q <= travel_d;
      excite_q <= servo_on_q & motor_energised;
    end
  end

  // pin pair routing, unknown codes leave the pair off
  generate
    for (genvar p = 0; p < `SSO_PAIRS; p++) begin : g_pair
      always_ff @(posedge clk) begin
        if (reset) begin
          pin_pair_out[p] <= 1'b1;
        end else if (clk_en) begin
          case (pinsel_q[4*p +: 4])
            SSO_SEL_MOTION: pin_pair_out[p] <= ~motion_q;
            SSO_SEL_READY:  pin_pair_out[p] <= ~ready_q;
            SSO_SEL_INDEX:  pin_pair_out[p] <= ~index_q;
            SSO_SEL_TRAVEL: pin_pair_out[p] <= travel_q;
            SSO_SEL_EXCITE: pin_pair_out[p] <= ~excite_q;
            default:        pin_pair_out[p] <= 1'b1;
          endcase
        end
      end
    end
  endgenerate

  assign wr_ctrl = reg_wr && reg_addr == `SSO_REG_CTRL;

  // control and configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      servo_on_q    <= 1'b0;
      thresh_q      <= `SSO_THRESH_RESET;
      limcfg_pend_q <= 2'h0;
      pinsel_q      <= `SSO_PINSEL_RESET;
    end else if (clk_en && reg_wr) begin
      if (wr_ctrl) begin
        servo_on_q <= reg_wdata[`SSO_CTRL_SERVO_ON];
      end
      // threshold clamped to its range, effective at once
      if (reg_addr == `SSO_REG_THRESH) begin
        thresh_q <= (reg_wdata[31:12] != 20'h0 || reg_wdata[11:0] > `SSO_THRESH_MAX) ?
                    `SSO_THRESH_MAX : reg_wdata[11:0];
      end
      if (reg_addr == `SSO_REG_LIMCFG) begin
        limcfg_pend_q <= reg_wdata[1:0];
      end
      if (reg_addr == `SSO_REG_PINSEL) begin
        pinsel_q <= reg_wdata[11:0];
      end
    end
  end

  // limit disables only move to the active copy on a restart
  always_ff @(posedge clk) begin
    if (reset) begin
      limcfg_act_q <= 2'h0;
    end else if (clk_en && wr_ctrl && reg_wdata[`SSO_CTRL_RESTART]) begin
      limcfg_act_q <= limcfg_pend_q;
    end
  end

  // interrupt events on rising edges, set wins over clear
  assign irq_event[`SSO_IRQ_ALARM]  = alarm_detect & ~alarm_q;
  assign irq_event[`SSO_IRQ_TRAVEL] = travel_d & ~travel_q;
  assign irq_event[`SSO_IRQ_MOTION] = (motor_speed > thresh_q) & ~motion_q;
  assign irq_clr = (reg_wr && reg_addr == `SSO_REG_IRQ_CLR) ?
                   reg_wdata[`SSO_IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_event;
      if (reg_wr && reg_addr == `SSO_REG_IRQ_EN) begin
        irq_en_q <= reg_wdata[`SSO_IRQ_W-1:0];
      end
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // read mux; motion state visible to the panel through status
  always_comb begin
    rdata_d = 32'h0;
    case (reg_addr)
      `SSO_REG_CTRL:     rdata_d[0] = servo_on_q;
      `SSO_REG_THRESH:   rdata_d[11:0] = thresh_q;
      `SSO_REG_LIMCFG:   rdata_d[3:0] = {limcfg_act_q, limcfg_pend_q};
      `SSO_REG_PINSEL:   rdata_d[11:0] = pinsel_q;
      `SSO_REG_STATUS:   rdata_d[5:0] = {index_q, excite_q, travel_q, ready_q, motion_q, alarm_q};
      `SSO_REG_IRQ_STAT: rdata_d[`SSO_IRQ_W-1:0] = irq_stat_q;
      `SSO_REG_IRQ_EN:   rdata_d[`SSO_IRQ_W-1:0] = irq_en_q;
      default:           rdata_d = 32'h0;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_d : 32'h0;
    end
  end

  // checks
  sequence s_clear_taken;
    clk_en && clr_req && !alarm_detect;
  endsequence

  sequence s_alarm_gone;
    !alarm_q ##0 !fault_flag_out;
  endsequence

  property p_fault_hold;
    @(posedge clk) disable iff (reset)
      alarm_q && !clr_req && clk_en |=> alarm_q && fault_flag_out;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("alarm dropped without clear");

  property p_fault_clear;
    @(posedge clk) disable iff (reset)
      s_clear_taken |=> s_alarm_gone;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("clear did not clear alarm");

  property p_power_up;
    @(posedge clk) reset |=> !alarm_q && !fault_flag_out;
  endproperty
  a_power_up: assert property (p_power_up) else $error("alarm present after reset");

  property p_motion;
    @(posedge clk) disable iff (reset)
      clk_en |=> motion_q == ($past(motor_speed) > $past(thresh_q));
  endproperty
  a_motion: assert property (p_motion) else $error("motion compare wrong");

  property p_thresh_range;
    @(posedge clk) disable iff (reset) thresh_q <= `SSO_THRESH_MAX;
  endproperty
  a_thresh_range: assert property (p_thresh_range) else $error("threshold out of range");

  property p_ready_alarm;
    @(posedge clk) disable iff (reset)
      clk_en && (alarm_q || !main_power_ok || !servo_on_q) |=> !ready_q;
  endproperty
  a_ready_alarm: assert property (p_ready_alarm) else $error("ready while not allowed");

  property p_travel_disabled;
    @(posedge clk) disable iff (reset)
      clk_en && limcfg_act_q == 2'h3 |=> !travel_q;
  endproperty
  a_travel_disabled: assert property (p_travel_disabled) else $error("overtravel with limits off");

  property p_excite;
    @(posedge clk) disable iff (reset)
      clk_en && servo_on_q && motor_energised |=> excite_q;
  endproperty
  a_excite: assert property (p_excite) else $error("excitation not reported");

  property p_pair_idle;
    @(posedge clk) disable iff (reset)
      clk_en && pinsel_q[11:8] == 4'h0 |=> pin_pair_out[2];
  endproperty
  a_pair_idle: assert property (p_pair_idle) else $error("unused pair driven low");

  property p_pair_travel;
    @(posedge clk) disable iff (reset)
      clk_en && pinsel_q[3:0] == 4'h6 |=> pin_pair_out[0] == $past(travel_q);
  endproperty
  a_pair_travel: assert property (p_pair_travel) else $error("overtravel code misrouted");

  property p_irq_sticky;
    @(posedge clk) disable iff (reset)
      clk_en && irq_event[`SSO_IRQ_ALARM] |=> irq_stat_q[`SSO_IRQ_ALARM];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("alarm event lost");

  property p_freeze;
    @(posedge clk) disable iff (reset)
      !clk_en |=> $stable(alarm_q) && $stable(fault_flag_out) && $stable(pin_pair_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_deb_clear;
    @(posedge clk) disable iff (reset)
      clk_en && deb_cnt_q[0] != DEB_LAST |=> $stable(deb_q[0]);
  endproperty
  a_deb_clear: assert property (p_deb_clear) else $error("clear input passed unfiltered");

  property p_deb_limit;
    @(posedge clk) disable iff (reset)
      clk_en && deb_cnt_q[1] != DEB_LAST |=> $stable(deb_q[1]);
  endproperty
  a_deb_limit: assert property (p_deb_limit) else $error("limit input passed unfiltered");

  property p_panel_clear;
    @(posedge clk) disable iff (reset)
      clk_en && panel_clear && !alarm_detect |=> s_alarm_gone;
  endproperty
  a_panel_clear: assert property (p_panel_clear) else $error("panel clear ignored");

  property p_ready_on;
    @(posedge clk) disable iff (reset)
      clk_en && servo_on_q && prep_done && !alarm_q && main_power_ok |=> ready_q;
  endproperty
  a_ready_on: assert property (p_ready_on) else $error("ready missing");

  sequence s_index_routed;
    clk_en && pinsel_q[11:8] == 4'h5 && index_q;
  endsequence

  property p_index_pin;
    @(posedge clk) disable iff (reset)
      s_index_routed |=> !pin_pair_out[2];
  endproperty
  a_index_pin: assert property (p_index_pin) else $error("index not on its pair");

  property p_travel_limit;
    @(posedge clk) disable iff (reset)
      clk_en && !deb_q[1] && !limcfg_act_q[0] |=> travel_q;
  endproperty
  a_travel_limit: assert property (p_travel_limit) else $error("forward limit not reported");

endmodule // sso_status_outputs

// [hw/sso_map.svh]
// constants for the servo status output block: register indices, resets, timing
// assumes a 250 MHz core clock and word-indexed register addresses
//
// Overview of operation
// - fault output high from alarm until cleared
// - low fault-clear input clears latched alarm
// - reset starts with no alarm latched
// - panel clear request acts like clear input
// - motion output low while speed above threshold
// - threshold 0 to 3000 rpm, default 20
// - motion state readable for the panel
// - ready low after servo-on and preparation
// - ready needs no alarm and main power
// - index output low at encoder index
// - index, overtravel, excitation only on selected pins
// - overtravel output high when a limit active
// - limit disable digits apply after restart
// - both limits disabled holds overtravel low
// - excitation output low while servo energised
// - pin select codes 1,2,5,6,7
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH

`define SSO_ADDR_W          4
`define SSO_REG_CTRL        4'h0
`define SSO_REG_THRESH      4'h1
`define SSO_REG_LIMCFG      4'h2
`define SSO_REG_PINSEL      4'h3
`define SSO_REG_STATUS      4'h4
`define SSO_REG_IRQ_STAT    4'h5
`define SSO_REG_IRQ_CLR     4'h6
`define SSO_REG_IRQ_EN      4'h7

`define SSO_CTRL_SERVO_ON   0
`define SSO_CTRL_RESTART    1

`define SSO_SPEED_W         12
`define SSO_THRESH_MAX      12'hbb8
`define SSO_THRESH_RESET    12'h014
`define SSO_PINSEL_RESET    12'h021
`define SSO_PAIRS           3

`define SSO_IRQ_ALARM       0
`define SSO_IRQ_TRAVEL      1
`define SSO_IRQ_MOTION      2
`define SSO_IRQ_W           3

`define SSO_CLK_MHZ         250
`define SSO_DEBOUNCE_NS     1000
`define SSO_DEBOUNCE_CYC    ((`SSO_DEBOUNCE_NS * `SSO_CLK_MHZ + 999) / 1000)
`define SSO_DEB_W           8

`endif

// [hw/sso_pkg.sv]
// types shared by the servo status output block
// assumes sso_map.svh supplies the numeric constants
package sso_pkg;
  typedef enum logic [3:0] {
    SSO_SEL_MOTION = 4'h1,
    SSO_SEL_READY  = 4'h2,
    SSO_SEL_INDEX  = 4'h5,
    SSO_SEL_TRAVEL = 4'h6,
    SSO_SEL_EXCITE = 4'h7
  } sso_pin_sel_type;
endpackage

// [dv/sso_host_model.sv]
// host controller model facing the discrete status outputs
// assumes the bench asks for clears and feeds it the overtravel pin level
module sso_host_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clear_req,
  input  wire logic cause_active,
  input  wire logic travel_level,
  output logic      fault_clear_in_n,
  output logic      ref_en
);
  timeunit 1ns;
  timeprecision 100ps;

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_clear_in_n <= 1'b1;
    end else begin
      fault_clear_in_n <= !(clear_req && !cause_active);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_en <= 1'b0;
    end else begin
      ref_en <= !travel_level;
    end
  end
endmodule // sso_host_model

// [dv/sso_status_outputs_bench.sv]
// self-checking bench for the servo status outputs
// assumes the register map of sso_map.svh and a host model on the pins
`include "sso_map.svh"

module sso_status_outputs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sso_pkg::*;

  logic                    clk = 0;
  logic                    reset = 1;
  logic                    clk_en = 1'b1;
  logic [`SSO_ADDR_W-1:0]  reg_addr = '0;
  logic [31:0]             reg_wdata = '0;
  logic                    reg_wr = 0;
  logic                    reg_rd = 0;
  logic [31:0]             reg_rdata;
  logic                    fault_clear_in_n;
  logic                    fwd_limit_in_n = 1;
  logic                    rev_limit_in_n = 1;
  logic                    index_in = 0;
  logic                    alarm_detect = 0;
  logic                    panel_clear = 0;
  logic [`SSO_SPEED_W-1:0] motor_speed = '0;
  logic                    prep_done = 0;
  logic                    main_power_ok = 0;
  logic                    motor_energised = 0;
  logic                    fault_flag_out;
  logic [`SSO_PAIRS-1:0]   pin_pair_out;
  logic                    irq;
  logic                    clear_req = 0;
  logic                    ref_en;
  int                      n_fail = 0;
  int                      n_compared = 0;

  sso_status_outputs i_sso_status_outputs (
    .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fault_clear_in_n(fault_clear_in_n), .fwd_limit_in_n(fwd_limit_in_n),
    .rev_limit_in_n(rev_limit_in_n), .index_in(index_in), .alarm_detect(alarm_detect),
    .panel_clear(panel_clear), .motor_speed(motor_speed), .prep_done(prep_done),
    .main_power_ok(main_power_ok), .motor_energised(motor_energised),
    .fault_flag_out(fault_flag_out), .pin_pair_out(pin_pair_out), .irq(irq)
  );

  sso_host_model i_sso_host_model (
    .clk(clk), .reset(reset), .clear_req(clear_req), .cause_active(alarm_detect),
    .travel_level(pin_pair_out[0]), .fault_clear_in_n(fault_clear_in_n), .ref_en(ref_en)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic pins(input logic [2:0] exp);
    check({29'h0, pin_pair_out}, {29'h0, exp});
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    wt(2);
    check({31'h0, fault_flag_out}, 32'h0);
    pins(3'b111);
    rd(`SSO_REG_THRESH, 32'h014);
    rd(`SSO_REG_PINSEL, 32'h021);
    rd(4'hf, 32'h0);
    wr(`SSO_REG_IRQ_EN, 32'h7);
    @(posedge clk);
    alarm_detect <= 1'b1;
    @(posedge clk);
    alarm_detect <= 1'b0;
    wt(4);
    check({31'h0, fault_flag_out}, 32'h1);
    check({31'h0, irq}, 32'h1);
    rd(`SSO_REG_IRQ_STAT, 32'h1);
    @(posedge clk);
    panel_clear <= 1'b1;
    @(posedge clk);
    panel_clear <= 1'b0;
    wt(3);
    check({31'h0, fault_flag_out}, 32'h0);
    wr(`SSO_REG_IRQ_CLR, 32'h1);
    wt(2);
    check({31'h0, irq}, 32'h0);
    @(posedge clk);
    alarm_detect <= 1'b1;
    @(posedge clk);
    alarm_detect <= 1'b0;
    wt(300);
    check({31'h0, fault_flag_out}, 32'h1);
    @(posedge clk);
    clear_req <= 1'b1;
    wt(265);
    check({31'h0, fault_flag_out}, 32'h0);
    @(posedge clk);
    clear_req <= 1'b0;
    motor_speed <= 12'h015;
    wt(4);
    pins(3'b110);
    rd(`SSO_REG_STATUS, 32'h2);
    @(posedge clk);
    motor_speed <= 12'h013;
    wt(4);
    pins(3'b111);
    wr(`SSO_REG_THRESH, 32'hfa0);
    rd(`SSO_REG_THRESH, 32'hbb8);
    wr(`SSO_REG_CTRL, 32'h1);
    @(posedge clk);
    prep_done     <= 1'b1;
    main_power_ok <= 1'b1;
    wt(4);
    pins(3'b101);
    rd(`SSO_REG_STATUS, 32'h4);
    @(posedge clk);
    main_power_ok <= 1'b0;
    wt(4);
    pins(3'b111);
    wr(`SSO_REG_PINSEL, 32'h576);
    wt(4);
    pins(3'b110);
    @(posedge clk);
    index_in        <= 1'b1;
    motor_energised <= 1'b1;
    wt(6);
    pins(3'b000);
    @(posedge clk);
    fwd_limit_in_n <= 1'b0;
    wt(265);
    pins(3'b001);
    check({31'h0, ref_en}, 32'h0);
    wr(`SSO_REG_LIMCFG, 32'h1);
    wt(4);
    pins(3'b001);
    wr(`SSO_REG_CTRL, 32'h3);
    wt(4);
    pins(3'b000);
    check({31'h0, ref_en}, 32'h1);
    @(posedge clk);
    rev_limit_in_n <= 1'b0;
    wt(265);
    pins(3'b001);
    wr(`SSO_REG_LIMCFG, 32'h3);
    wr(`SSO_REG_CTRL, 32'h3);
    wt(4);
    pins(3'b000);
    rd(`SSO_REG_LIMCFG, 32'hf);
    rd(`SSO_REG_IRQ_STAT, 32'h7);
    @(posedge clk);
    clk_en       <= 1'b0;
    alarm_detect <= 1'b1;
    @(posedge clk);
    alarm_detect <= 1'b0;
    wt(3);
    check({31'h0, fault_flag_out}, 32'h0);
    @(posedge clk);
    clk_en       <= 1'b1;
    alarm_detect <= 1'b1;
    @(posedge clk);
    alarm_detect <= 1'b0;
    wt(3);
    check({31'h0, fault_flag_out}, 32'h1);
    results();
  end
endmodule // sso_status_outputs_bench
